/* design/serial_flash_command_decoder.sv */
`timescale 1ns/1ps
// Functional notes
// - 0Bh and 03h: 3 address bytes, 0Bh adds dummy; single-line data until deselect.
// - 3Bh: single address, dummy, data on two lines, line 1 odd bits.
// - BBh: address and mode byte over two lines, data back on two lines.
// - 6Bh: single address, dummy, data on four lines, line 3 bits 7,3.
// - EBh: address and mode over four lines, data on four lines.
// - four-line I/O read: four idle clocks, then high nibble first.
// - erase opcodes 81h,20h,52h,D8h with address; 60h,C7h chip erase without.
// - program opcodes 02h,A2h,32h: address then data on one, two, four lines.
// - 06h sets the write enable latch.
// - 04h clears the write enable latch.
// - 50h arms only the next status write as a volatile update.
// - secure area 44h erase, 42h program, 48h read with dummy byte.
// - secure areas 1..3 by address bits 15..9, offset in bits 8..0.
// - 05h returns low status byte, 35h the high one.
// - 25h plus one dummy byte turns on active status signalling.
// - 01h takes two data bytes into the status bits.
// - 9Fh returns maker code then two part code bytes.
// - 90h,92h,94h maker and part reads; two- and four-line add dummy.
// - B9h enters deep power-down.
// - ABh wakes; with address it returns one identification byte.
// - two-line address: line 1 carries A23 first, odd bits.
// - write and control commands must end on a byte boundary.
// - four-line commands only when the quad enable bit is set.
// - unknown opcode: standby, outputs off until next select.
// - write-type completion clears the write enable latch.
module serial_flash_command_decoder #(
    // identification values are arbitrary
    parameter logic [7:0] MAKER_ID = 8'h5A,
    parameter logic [7:0] PART_ID_HI = 8'h41,
    parameter logic [7:0] PART_ID_LO = 8'h13,
    parameter logic [7:0] ELEC_ID = 8'h12
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic busy,
    output logic [23:0] array_addr,
    output logic array_rd,
    output logic [1:0] secure_sel,
    input wire logic [7:0] array_rdata,
    output logic prog_valid,
    output logic [7:0] prog_data,
    output logic op_go,
    output logic [7:0] op_code,
    output logic [23:0] op_addr,
    output logic op_volatile,
    output logic [15:0] status_word,
    output logic quad_enable_bit,
    output logic asi_enable,
    output logic deep_sleep
);
    import serial_flash_pkg::*;

    // ****************************************
    // pin synchronisers and edge detection
    // ****************************************
    logic [2:0] cs_s, ck_s;
    logic [3:0] io_s1, io_s2, io_s3;
    logic cs_lvl_r, ck_lvl_r;
    logic cs_fall, cs_rise, sclk_rise, sclk_fall;

    // three stages; a change counts only when stages two and three agree
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cs_s <= 3'h7;
            ck_s <= 3'h0;
            io_s1 <= 4'h0;
            io_s2 <= 4'h0;
            io_s3 <= 4'h0;
            cs_lvl_r <= 1'b1;
            ck_lvl_r <= 1'b0;
        end else begin
            cs_s <= {cs_s[1:0], cs_n_pin};
            ck_s <= {ck_s[1:0], sclk_pin};
            io_s1 <= io_in;
            io_s2 <= io_s1;
            io_s3 <= io_s2;
            if (cs_s[1] == cs_s[2]) cs_lvl_r <= cs_s[2];
            if (ck_s[1] == ck_s[2]) ck_lvl_r <= ck_s[2];
        end
    end

    assign cs_fall = (cs_s[1] == cs_s[2]) && !cs_s[2] && cs_lvl_r;
    assign cs_rise = (cs_s[1] == cs_s[2]) && cs_s[2] && !cs_lvl_r;
    // clock edges outside a frame are ignored
    assign sclk_rise = (ck_s[1] == ck_s[2]) && ck_s[2] && !ck_lvl_r && !cs_lvl_r;
    assign sclk_fall = (ck_s[1] == ck_s[2]) && !ck_s[2] && ck_lvl_r && !cs_lvl_r;

    // ****************************************
    // state
    // ****************************************
    phase_t phase_r;
    logic [7:0] op_r, sh_in_r, sh_out_r, lo_r, hi_r;
    logic [2:0] bcnt_r;
    logic [1:0] acnt_r, pend_r;
    logic [3:0] dcnt_r, nbytes_r;
    logic [23:0] addr_r;
    logic [15:0] status_r;
    logic wel_r, vol_r;

    // ****************************************
    // opcode decode
    // ****************************************
    logic [7:0] cur_op, nxt_byte, src_byte;
    logic [2:0] aw, dw, w;
    logic [3:0] dclk;
    logic [1:0] abytes;
    logic known, dout, din, wtype, quad, accept, byte_done;

    always_comb begin
        known = 1'b1;
        abytes = 2'd0;
        aw = 3'd1;
        dclk = 4'd0;
        dw = 3'd1;
        dout = 1'b0;
        din = 1'b0;
        wtype = 1'b0;
        quad = 1'b0;
        case (cur_op)
            OP_ARRAY_READ: begin abytes = ADDR_BYTES; dout = 1'b1; end
            OP_FAST_ARRAY_READ: begin
                abytes = ADDR_BYTES; dclk = DUMMY_BYTE_CLOCKS; dout = 1'b1;
            end
            OP_DUAL_OUTPUT_READ: begin
                abytes = ADDR_BYTES; dclk = DUMMY_BYTE_CLOCKS; dw = 3'd2; dout = 1'b1;
            end
            OP_TWO_LINE_IO_READ: begin
                abytes = ADDR_BYTES; aw = 3'd2; dclk = DUAL_MODE_CLOCKS; dw = 3'd2;
                dout = 1'b1;
            end
            OP_QUAD_OUTPUT_READ: begin
                abytes = ADDR_BYTES; dclk = DUMMY_BYTE_CLOCKS; dw = 3'd4; dout = 1'b1;
                quad = 1'b1;
            end
            OP_FOUR_LINE_IO_READ: begin
                abytes = ADDR_BYTES; aw = 3'd4; dclk = QUAD_MODE_AND_GAP_CLOCKS;
                dw = 3'd4; dout = 1'b1; quad = 1'b1;
            end
            OP_PAGE_ERASE, OP_SECTOR_ERASE, OP_HALF_BLOCK_ERASE, OP_FULL_BLOCK_ERASE,
            OP_SECURE_AREA_ERASE: begin
                abytes = ADDR_BYTES; wtype = 1'b1;
            end
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: wtype = 1'b1;
            OP_PAGE_PROGRAM, OP_SECURE_AREA_PROGRAM: begin
                abytes = ADDR_BYTES; din = 1'b1; wtype = 1'b1;
            end
            OP_DUAL_INPUT_PROGRAM: begin
                abytes = ADDR_BYTES; din = 1'b1; wtype = 1'b1; dw = 3'd2;
            end
            OP_QUAD_INPUT_PROGRAM: begin
                abytes = ADDR_BYTES; din = 1'b1; wtype = 1'b1; dw = 3'd4; quad = 1'b1;
            end
            OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_VOLATILE_WRITE_ENABLE,
            OP_DEEP_SLEEP: known = 1'b1;
            OP_SECURE_AREA_READ: begin
                abytes = ADDR_BYTES; dclk = DUMMY_BYTE_CLOCKS; dout = 1'b1;
            end
            OP_STATUS_LOW_READ, OP_STATUS_HIGH_READ, OP_IDENTITY_READ: dout = 1'b1;
            OP_ACTIVE_STATUS_SIGNAL: dclk = DUMMY_BYTE_CLOCKS;
            OP_STATUS_WRITE: begin din = 1'b1; wtype = 1'b1; end
            OP_MAKER_PART_READ, OP_WAKE_AND_ID: begin
                abytes = ADDR_BYTES; dout = 1'b1;
            end
            OP_DUAL_MAKER_PART_READ: begin
                abytes = ADDR_BYTES; dclk = DUMMY_BYTE_CLOCKS; dw = 3'd2; dout = 1'b1;
            end
            OP_QUAD_MAKER_PART_READ: begin
                abytes = ADDR_BYTES; dclk = DUMMY_BYTE_CLOCKS; dw = 3'd4; dout = 1'b1;
                quad = 1'b1;
            end
            default: known = 1'b0;
        endcase
    end

    // asleep, only the wake opcode is heard
    assign accept = known && (!quad || status_r[STATUS_QE_BIT])
        && (!deep_sleep || cur_op == OP_WAKE_AND_ID);
    assign w = (phase_r == PH_ADDR) ? aw : (phase_r == PH_DIN || phase_r == PH_DOUT) ? dw : 3'd1;
    assign byte_done = ({1'b0, bcnt_r} + {1'b0, w}) == 4'd8;
    assign cur_op = (phase_r == PH_OP) ? nxt_byte : op_r;

    // msb first; lanes 3..0 map to the low bits of each step
    always_comb begin
        case (w)
            3'd2: nxt_byte = {sh_in_r[5:0], io_s3[1:0]};
            3'd4: nxt_byte = {sh_in_r[3:0], io_s3};
            default: nxt_byte = {sh_in_r[6:0], io_s3[0]};
        endcase
    end

    // ****************************************
    // command sequencing on sampled clock edges
    // ****************************************
    logic commit, after_body;
    phase_t body_ph;

    // where the command goes once its address bytes are in
    always_comb begin
        if (dclk != 4'd0) body_ph = PH_DUMMY;
        else if (dout) body_ph = PH_DOUT;
        else if (din) body_ph = PH_DIN;
        else body_ph = PH_HOLD;
    end

    assign after_body = (phase_r == PH_HOLD) || (phase_r == PH_DIN);
    // partial bytes at deselect void the command
    assign commit = cs_rise && after_body && bcnt_r == 3'd0;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            phase_r <= PH_IDLE;
            op_r <= 8'h00;
            sh_in_r <= 8'h00;
            bcnt_r <= 3'd0;
            acnt_r <= 2'd0;
            dcnt_r <= 4'd0;
            nbytes_r <= 4'd0;
            addr_r <= 24'h000000;
            lo_r <= 8'h00;
            hi_r <= 8'h00;
            prog_valid <= 1'b0;
            prog_data <= 8'h00;
        end else begin
            prog_valid <= 1'b0;
            if (cs_fall) begin
                phase_r <= PH_OP;
                bcnt_r <= 3'd0;
                acnt_r <= 2'd0;
                dcnt_r <= 4'd0;
                nbytes_r <= 4'd0;
            end else if (cs_rise) begin
                phase_r <= PH_IDLE;
            end else if (pend_r[1]) begin
                addr_r <= addr_r + 24'h000001; // reads run on until deselect
                if (nbytes_r != 4'hF) nbytes_r <= nbytes_r + 4'd1;
            end else if (sclk_rise) begin
                // bits past the body keep counting, so a stray bit voids the commit
                if (phase_r == PH_OP || phase_r == PH_ADDR || phase_r == PH_DIN ||
                    phase_r == PH_DOUT || phase_r == PH_HOLD) begin
                    sh_in_r <= nxt_byte;
                    bcnt_r <= byte_done ? 3'd0 : bcnt_r + w;
                end
                case (phase_r)
                    PH_OP: if (byte_done) begin
                        op_r <= nxt_byte;
                        if (!accept) phase_r <= PH_STANDBY;
                        else if (abytes != 2'd0) phase_r <= PH_ADDR;
                        else phase_r <= body_ph;
                    end
                    PH_ADDR: if (byte_done) begin
                        addr_r <= {addr_r[15:0], nxt_byte};
                        acnt_r <= acnt_r + 2'd1;
                        if (acnt_r == ADDR_BYTES - 2'd1) phase_r <= body_ph;
                    end
                    PH_DUMMY: begin
                        dcnt_r <= dcnt_r + 4'd1;
                        if (dcnt_r == dclk - 4'd1) phase_r <= dout ? PH_DOUT : PH_HOLD;
                    end
                    PH_DIN: if (byte_done) begin
                        prog_valid <= (op_r != OP_STATUS_WRITE);
                        prog_data <= nxt_byte;
                        if (nbytes_r == 4'd0) lo_r <= nxt_byte;
                        if (nbytes_r == 4'd1) hi_r <= nxt_byte;
                        if (nbytes_r != 4'hF) nbytes_r <= nbytes_r + 4'd1;
                    end
                    default: phase_r <= phase_r;
                endcase
            end
        end
    end

    // ****************************************
    // latch, status and mode bits
    // ****************************************
    logic allowed;

    // status write may also run on the volatile arm alone
    assign allowed = wel_r || (op_r == OP_STATUS_WRITE && vol_r);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            wel_r <= 1'b0;
            vol_r <= 1'b0;
            status_r <= STATUS_RESET;
            asi_enable <= 1'b0;
            deep_sleep <= 1'b0;
            op_go <= 1'b0;
            op_code <= 8'h00;
            op_addr <= 24'h000000;
            op_volatile <= 1'b0;
        end else begin
            op_go <= 1'b0;
            if (sclk_rise && phase_r == PH_OP && byte_done && accept &&
                nxt_byte == OP_WAKE_AND_ID) deep_sleep <= 1'b0;
            if (commit) begin
                case (op_r)
                    OP_WRITE_ENABLE: wel_r <= 1'b1;
                    OP_WRITE_DISABLE: wel_r <= 1'b0;
                    OP_VOLATILE_WRITE_ENABLE: vol_r <= 1'b1;
                    OP_DEEP_SLEEP: deep_sleep <= 1'b1;
                    OP_ACTIVE_STATUS_SIGNAL: asi_enable <= 1'b1;
                    default: if (wtype && allowed && (!din || (nbytes_r != 4'd0 &&
                        (op_r != OP_STATUS_WRITE || nbytes_r == STATUS_WRITE_BYTES)))) begin
                        op_go <= 1'b1;
                        op_code <= op_r;
                        op_addr <= addr_r;
                        op_volatile <= vol_r && op_r == OP_STATUS_WRITE;
                        wel_r <= 1'b0;
                        if (op_r == OP_STATUS_WRITE) begin
                            status_r <= ({hi_r, lo_r} & STATUS_WRITABLE) |
                                (status_r & ~STATUS_WRITABLE);
                            vol_r <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    assign status_word = {status_r[15:2], wel_r, busy};
    assign quad_enable_bit = status_r[STATUS_QE_BIT];

    // ****************************************
    // read data source and output shifter
    // ****************************************
    logic array_src;

    assign array_src = op_r == OP_ARRAY_READ || op_r == OP_FAST_ARRAY_READ ||
        op_r == OP_DUAL_OUTPUT_READ || op_r == OP_TWO_LINE_IO_READ ||
        op_r == OP_QUAD_OUTPUT_READ || op_r == OP_FOUR_LINE_IO_READ ||
        op_r == OP_SECURE_AREA_READ;

    always_comb begin
        case (op_r)
            OP_STATUS_LOW_READ: src_byte = status_word[7:0];
            OP_STATUS_HIGH_READ: src_byte = status_word[15:8];
            OP_IDENTITY_READ: begin
                case (nbytes_r)
                    4'd0: src_byte = MAKER_ID;
                    4'd1: src_byte = PART_ID_HI;
                    4'd2: src_byte = PART_ID_LO;
                    default: src_byte = 8'h00;
                endcase
            end
            OP_MAKER_PART_READ, OP_DUAL_MAKER_PART_READ,
            OP_QUAD_MAKER_PART_READ: src_byte = addr_r[0] ? PART_ID_LO : MAKER_ID;
            OP_WAKE_AND_ID: src_byte = ELEC_ID;
            default: src_byte = array_rdata;
        endcase
    end

    // secure area decode from the running address
    always_comb begin
        secure_sel = 2'd0;
        if (op_r == OP_SECURE_AREA_READ || op_r == OP_SECURE_AREA_PROGRAM ||
            op_r == OP_SECURE_AREA_ERASE) begin
            if (addr_r[23:16] == 8'h00) begin
                if (addr_r[15:9] == SECURE_AREA1_TAG) secure_sel = 2'd1;
                if (addr_r[15:9] == SECURE_AREA2_TAG) secure_sel = 2'd2;
                if (addr_r[15:9] == SECURE_AREA3_TAG) secure_sel = 2'd3;
            end
        end
    end

    assign array_addr = addr_r;
    assign array_rd = pend_r[0] && array_src;

    // load two cycles after the byte is due, leaving the array a cycle to answer
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pend_r <= 2'b00;
        end else begin
            pend_r <= {pend_r[0], 1'b0};
            if (cs_rise || cs_fall) pend_r <= 2'b00;
            else if (sclk_rise && ((phase_r == PH_DOUT && byte_done) ||
                (phase_r == PH_DUMMY && dout && dcnt_r == dclk - 4'd1) ||
                (body_ph == PH_DOUT && ((phase_r == PH_OP && byte_done && accept &&
                abytes == 2'd0) || (phase_r == PH_ADDR && byte_done &&
                acnt_r == 2'd2))))) pend_r[0] <= 1'b1;
        end
    end

    // new bits leave on the falling clock, read by the host on the next rise
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sh_out_r <= 8'h00;
            io_out <= 4'h0;
            io_oe <= 4'h0;
        end else begin
            if (pend_r[1]) sh_out_r <= src_byte;
            if (cs_rise || cs_fall || phase_r != PH_DOUT) begin
                io_oe <= 4'h0;
            end else if (sclk_fall) begin
                case (dw)
                    3'd2: begin
                        io_out <= {2'b00, sh_out_r[7:6]};
                        io_oe <= 4'h3;
                        sh_out_r <= {sh_out_r[5:0], 2'b00};
                    end
                    3'd4: begin
                        io_out <= sh_out_r[7:4];
                        io_oe <= 4'hF;
                        sh_out_r <= {sh_out_r[3:0], 4'h0};
                    end
                    default: begin
                        io_out <= {2'b00, sh_out_r[7], 1'b0};
                        io_oe <= 4'h2;
                        sh_out_r <= {sh_out_r[6:0], 1'b0};
                    end
                endcase
            end
        end
    end
endmodule

/* common/serial_flash_pkg.sv */
package serial_flash_pkg;
    // ****************************************
    // opcodes
    // ****************************************
    localparam logic [7:0] OP_ARRAY_READ = 8'h03;
    localparam logic [7:0] OP_FAST_ARRAY_READ = 8'h0B;
    localparam logic [7:0] OP_DUAL_OUTPUT_READ = 8'h3B;
    localparam logic [7:0] OP_TWO_LINE_IO_READ = 8'hBB;
    localparam logic [7:0] OP_QUAD_OUTPUT_READ = 8'h6B;
    localparam logic [7:0] OP_FOUR_LINE_IO_READ = 8'hEB;
    localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] OP_FULL_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_DUAL_INPUT_PROGRAM = 8'hA2;
    localparam logic [7:0] OP_QUAD_INPUT_PROGRAM = 8'h32;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_VOLATILE_WRITE_ENABLE = 8'h50;
    localparam logic [7:0] OP_SECURE_AREA_ERASE = 8'h44;
    localparam logic [7:0] OP_SECURE_AREA_PROGRAM = 8'h42;
    localparam logic [7:0] OP_SECURE_AREA_READ = 8'h48;
    localparam logic [7:0] OP_STATUS_LOW_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_HIGH_READ = 8'h35;
    localparam logic [7:0] OP_ACTIVE_STATUS_SIGNAL = 8'h25;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_IDENTITY_READ = 8'h9F;
    localparam logic [7:0] OP_MAKER_PART_READ = 8'h90;
    localparam logic [7:0] OP_DUAL_MAKER_PART_READ = 8'h92;
    localparam logic [7:0] OP_QUAD_MAKER_PART_READ = 8'h94;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE_AND_ID = 8'hAB;
    // ****************************************
    // counts, fields and reset values
    // ****************************************
    localparam logic [1:0] ADDR_BYTES = 2'd3;
    localparam logic [3:0] DUMMY_BYTE_CLOCKS = 4'd8;
    localparam logic [3:0] DUAL_MODE_CLOCKS = 4'd4;
    localparam logic [3:0] QUAD_MODE_AND_GAP_CLOCKS = 4'd6;
    localparam logic [3:0] STATUS_WRITE_BYTES = 4'd2;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_WEL_BIT = 1;
    localparam int STATUS_QE_BIT = 9;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] STATUS_WRITABLE = 16'hFFFC;
    localparam logic [6:0] SECURE_AREA1_TAG = 7'b0001000;
    localparam logic [6:0] SECURE_AREA2_TAG = 7'b0010000;
    localparam logic [6:0] SECURE_AREA3_TAG = 7'b0011000;
    // ****************************************
    // command phases
    // ****************************************
    typedef enum logic [7:0] {
        PH_IDLE = 8'b0000_0001,
        PH_OP = 8'b0000_0010,
        PH_ADDR = 8'b0000_0100,
        PH_DUMMY = 8'b0000_1000,
        PH_DIN = 8'b0001_0000,
        PH_DOUT = 8'b0010_0000,
        PH_HOLD = 8'b0100_0000,
        PH_STANDBY = 8'b1000_0000
    } phase_t;
endpackage

/* testbench/spi_host_model.sv */
`timescale 1ns/1ps
// host end of the link, mode 0: sclk rests low between frames
module spi_host_model (
    output logic cs_n,
    output logic sclk,
    output logic [3:0] io,
    input wire logic [3:0] line
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io = 4'h5;
    end
    // released lines toggle so a stale level never reads as data
    task automatic tick(input logic d, output logic [3:0] q);
        io = {~io[3:1], d};
        #40 sclk = 1'b1;
        #39 q = line; // late sample covers the sync lag
        #1 sclk = 1'b0;
    endtask
    task automatic byte8(input logic [7:0] v);
        logic [3:0] q;
        for (int i = 7; i >= 0; i--) tick(v[i], q);
    endtask
    task automatic addr24(input logic [23:0] a);
        byte8(a[23:16]);
        byte8(a[15:8]);
        byte8(a[7:0]);
    endtask
    task automatic recv(input int w, output logic [7:0] b);
        logic [3:0] q;
        for (int i = 0; i < 8 / w; i++) begin
            tick(~io[0], q);
            if (w == 4) b = {b[3:0], q};
            else b = (w == 1) ? {b[6:0], q[1]} : {b[5:0], q[1:0]};
        end
    endtask
    task automatic sel();
        cs_n = 1'b0;
    endtask
    task automatic desel();
        #40 cs_n = 1'b1;
        #80;
    endtask
endmodule

/* testbench/serial_flash_properties.sv */
`timescale 1ns/1ps
module serial_flash_properties (
    input wire logic clock,
    input wire logic rstn,
    input wire logic cs_n_pin,
    input wire logic busy,
    input wire logic [3:0] io_oe,
    input wire logic op_go,
    input wire logic op_volatile,
    input wire logic [15:0] status_word,
    input wire logic quad_enable_bit,
    input wire logic asi_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    oe_idle_a: assert property (cs_n_pin [*8] ##0 !asi_enable |-> io_oe == 4'h0)
        else $error("oe outside frame");
    go_deselect_a: assert property (op_go |-> cs_n_pin && $past(cs_n_pin, 2))
        else $error("go inside frame");
    go_clears_a: assert property (op_go |-> ##[1:2] !status_word[1])
        else $error("latch kept");
    go_latch_a: assert property (op_go && !op_volatile |-> $past(status_word[1]))
        else $error("go without latch");
    quad_qe_a: assert property (io_oe == 4'hF |-> quad_enable_bit)
        else $error("quad without qe");
    oe_shape_a: assert property (io_oe != 4'h0 |-> io_oe inside {4'h2, 4'h3, 4'hF})
        else $error("bad oe");
    busy_seen_a: assert property ($stable(busy) [*3] |-> status_word[0] == busy)
        else $error("busy bit");
    qe_copy_a: assert property ($stable(status_word[9]) [*2] |-> quad_enable_bit == status_word[9])
        else $error("qe copy");
endmodule
bind serial_flash_command_decoder serial_flash_properties chk_u (.*);

/* testbench/serial_flash_command_decoder_test.sv */
`timescale 1ns/1ps
module serial_flash_command_decoder_test;
    import serial_flash_pkg::*;
    logic clock = 0, rstn = 0, busy = 0, cs_n_pin, sclk_pin, array_rd, prog_valid, op_go;
    logic op_volatile, quad_enable_bit, asi_enable, deep_sleep;
    logic [3:0] hio, io_in, io_out, io_oe, q;
    logic [23:0] array_addr, op_addr;
    logic [1:0] secure_sel;
    logic [7:0] array_rdata, prog_data, op_code, b, pq[$];
    logic [15:0] status_word;
    int miscompares = 0, compares = 0, gos = 0;
    always #5 clock = ~clock;
    // array stand-in: data follows the address
    assign array_rdata = array_addr[7:0] ^ 8'h3C;
    assign io_in = (io_oe & io_out) | (~io_oe & hio);
    always @(posedge clock) begin
        if (op_go) gos++;
        if (prog_valid) pq.push_back(prog_data);
    end
    serial_flash_command_decoder dut_u (.*);
    spi_host_model host_u (.cs_n(cs_n_pin), .sclk(sclk_pin), .io(hio), .line(io_in));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op);
        host_u.sel();
        host_u.byte8(op);
        host_u.desel();
    endtask
    task automatic t_latch();
        cmd(OP_WRITE_ENABLE);
        check(status_word[1], 1'b1);
        host_u.sel();
        host_u.byte8(OP_STATUS_LOW_READ);
        host_u.recv(1, b);
        host_u.desel();
        check(b, 8'h02);
        cmd(OP_WRITE_DISABLE);
        check(status_word[1], 1'b0);
        host_u.sel();
        host_u.byte8(OP_WRITE_ENABLE);
        host_u.tick(1'b0, q);
        host_u.desel();
        check(status_word[1], 1'b0);
        $display("latch test done");
    endtask
    // nak marks an opcode that the decoder must refuse
    task automatic t_read(input logic [7:0] op, input int w, input int dummy_bytes, input bit nak);
        host_u.sel();
        host_u.byte8(op);
        host_u.addr24(24'h0100FE);
        if (dummy_bytes) host_u.byte8(8'h00);
        for (int j = 0; j < 3; j++) begin
            host_u.recv(w, b);
            if (nak) check(io_oe, 4'h0);
            else check(b, 8'(8'hFE + j) ^ 8'h3C);
        end
        host_u.desel();
        $display("read test %h done", op);
    endtask
    task automatic t_prog();
        for (int k = 0; k < 2; k++) begin
            int g;
            if (k == 1) cmd(OP_WRITE_ENABLE);
            g = gos;
            pq.delete();
            host_u.sel();
            host_u.byte8(OP_PAGE_PROGRAM);
            host_u.addr24(24'h012345);
            host_u.byte8(8'hA5);
            host_u.byte8(8'h5A);
            host_u.desel();
            check(gos - g, k);
        end
        check({pq[0], pq[1]}, 16'hA55A);
        check(op_addr, 24'h012345);
        check(op_code, OP_PAGE_PROGRAM);
        check(status_word[1], 1'b0);
        $display("program test done");
    endtask
    task automatic t_id_sleep();
        host_u.sel();
        host_u.byte8(OP_IDENTITY_READ);
        host_u.recv(1, b);
        check(b, 8'h5A);
        host_u.recv(1, b);
        check(b, 8'h41);
        host_u.desel();
        cmd(OP_DEEP_SLEEP);
        check(deep_sleep, 1'b1);
        cmd(OP_WAKE_AND_ID);
        check(deep_sleep, 1'b0);
        host_u.sel();
        host_u.byte8(OP_ACTIVE_STATUS_SIGNAL);
        host_u.byte8(8'h00);
        host_u.desel();
        check(asi_enable, 1'b1);
        $display("id and sleep test done");
    endtask
    // volatile arm lets the status write set quad enable, then a quad read is heard
    task automatic t_quad();
        cmd(OP_VOLATILE_WRITE_ENABLE);
        host_u.sel();
        host_u.byte8(OP_STATUS_WRITE);
        host_u.byte8(8'h00);
        host_u.byte8(8'h02);
        host_u.desel();
        check(quad_enable_bit, 1'b1);
        check(op_volatile, 1'b1);
        t_read(OP_QUAD_OUTPUT_READ, 4, 1, 0);
        $display("quad test done");
    endtask
    initial begin
        repeat (50000) @(posedge clock);
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (16) @(negedge clock);
        rstn = 1'b1;
        t_latch();
        t_read(OP_ARRAY_READ, 1, 0, 0);
        t_read(OP_FAST_ARRAY_READ, 1, 1, 0);
        t_read(OP_DUAL_OUTPUT_READ, 2, 1, 0);
        t_read(OP_QUAD_OUTPUT_READ, 1, 1, 1);
        t_read(8'hE7, 1, 0, 1);
        t_prog();
        t_quad();
        t_id_sleep();
        finish_test();
    end
endmodule
